// [hw/ulms_pkg.sv]
package ulms_pkg;

    // Register byte addresses on the APB side, one aligned word each.
    localparam logic [7:0] ULMS_ADDR_HOLDING   = 8'h00;
    localparam logic [7:0] ULMS_ADDR_INT_EN    = 8'h04;
    localparam logic [7:0] ULMS_ADDR_INT_FIFO  = 8'h08;
    localparam logic [7:0] ULMS_ADDR_LINE_CTL  = 8'h0c;
    localparam logic [7:0] ULMS_ADDR_MODEM_CTL = 8'h10;
    localparam logic [7:0] ULMS_ADDR_LINE_STS  = 8'h14;
    localparam logic [7:0] ULMS_ADDR_MODEM_STS = 8'h18;
    localparam logic [7:0] ULMS_ADDR_SCRATCH   = 8'h1c;
    localparam logic [7:0] ULMS_ADDR_DIV_LOW   = 8'h20;
    localparam logic [7:0] ULMS_ADDR_DIV_HIGH  = 8'h24;

    // Reset and power-up values.
    localparam logic [7:0] ULMS_RST_INT_EN     = 8'h00;
    localparam logic [7:0] ULMS_RST_FIFO_CTL   = 8'h00;
    localparam logic [7:0] ULMS_RST_INT_STS    = 8'h01;
    localparam logic [7:0] ULMS_RST_LINE_CTL   = 8'h00;
    localparam logic [7:0] ULMS_RST_MODEM_CTL  = 8'h00;
    localparam logic [7:0] ULMS_RST_LINE_STS   = 8'h60;
    localparam logic [7:0] ULMS_RST_SCRATCH    = 8'hff;
    localparam logic [7:0] ULMS_PWR_DIV_LOW    = 8'h01;
    localparam logic [7:0] ULMS_PWR_DIV_HIGH   = 8'h00;

    // Field positions.
    localparam int ULMS_IER_LINE_BIT  = 2;
    localparam int ULMS_IER_MODEM_BIT = 3;
    localparam int ULMS_FCR_EN_BIT    = 0;
    localparam int ULMS_FCR_RXCLR_BIT = 1;
    localparam int ULMS_FCR_TXCLR_BIT = 2;
    localparam int ULMS_FCR_DMA_BIT   = 3;
    localparam int ULMS_FCR_TRIG_LSB  = 6;
    localparam int ULMS_LCR_PAR_EN    = 3;
    localparam int ULMS_LCR_PAR_EVEN  = 4;
    localparam int ULMS_LCR_PAR_FORCE = 5;
    localparam int ULMS_LCR_TX_BREAK  = 6;
    localparam int ULMS_MCR_DTR_BIT   = 0;
    localparam int ULMS_MCR_RTS_BIT   = 1;
    localparam int ULMS_MCR_OUT1_BIT  = 2;
    localparam int ULMS_MCR_OUT2_BIT  = 3;
    localparam int ULMS_MCR_LOOP_BIT  = 4;

    // Receive trigger levels selected by the two trigger bits.
    localparam logic [4:0] ULMS_TRIG_0 = 5'd1;
    localparam logic [4:0] ULMS_TRIG_1 = 5'd4;
    localparam logic [4:0] ULMS_TRIG_2 = 5'd8;
    localparam logic [4:0] ULMS_TRIG_3 = 5'd14;

    // Interrupt status identification codes.
    localparam logic [2:0] ULMS_ID_LINE  = 3'b011;
    localparam logic [2:0] ULMS_ID_MODEM = 3'b000;

    localparam int ULMS_FIFO_DEPTH = 16;

endpackage

// [hw/ulms_top.sv]
// Chosen here: register access over APB and the register offsets.
`timescale 1ns/10ps
// Notes on behaviour
// R1: Data ready while any received character waits.
// R2: Full FIFO: set overrun, drop new character.
// R3: Parity error tags the character being read.
// R4: Framing error tags the character being read.
// R5: Long low line: break tag, one character.
// R6: No further break until line returns high.
// R7: Holding empty set on move, cleared on write.
// R8: FIFO mode: holding empty means FIFO empty.
// R9: Transmitter empty needs holding and shifter empty.
// R10: FIFO error while any tagged character stored.
// R11: Modem input changes set deltas, request interrupt.
// R12: Ring delta only on low-to-high ring input.
// R13: High clear-to-send halts transmitter after character.
// R14: Normal mode: status bits show inverted inputs.
// R15: Loopback: status bits mirror modem control bits.
// R16: Eight-bit scratch register, store and return.
// R17: Divisor is high byte then low byte.
// R18: Divisor set at power-up, kept on reset.
// R19: Reset clears deltas, loads inverted input levels.
// R20: Line interrupt: overrun at once, tags when presented.
// R21: Modem control bit 4 selects local loopback.
// R22: Reading modem status clears the delta flags.
// R23: Reset values of control and status registers.
// R24: Reset drives receive-ready high, transmit-ready low.
module ulms_top
    import ulms_pkg::*;
#(
    parameter int DEPTH = ULMS_FIFO_DEPTH
) (
    input  wire logic        core_clk,
    input  wire logic        sys_rst,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        rx_char_valid,
    input  wire logic [7:0]  rx_char_data,
    input  wire logic        rx_parity_bit,
    input  wire logic        rx_stop_bit,
    input  wire logic        rx_break,
    input  wire logic        rx_pin,
    output logic             rx_line,
    output logic      [7:0]  tx_data,
    output logic             tx_data_valid,
    input  wire logic        tx_take,
    input  wire logic        tx_shift_busy,
    input  wire logic        tx_serial,
    output logic             tx_pin,
    output logic             tx_halt,
    input  wire logic        cts_n,
    input  wire logic        dsr_n,
    input  wire logic        ring_indicator_n,
    input  wire logic        carrier_detect_n,
    output logic             rts_n,
    output logic             dtr_n,
    output logic      [15:0] baud_divisor,
    output logic      [7:0]  line_control,
    output logic             loopback,
    output logic             interrupt_output_enable,
    output logic             receive_ready_n,
    output logic             transmit_ready_n,
    output logic             line_irq_req,
    output logic             modem_irq_req
);

    localparam int AW = $clog2(DEPTH);
    localparam logic [AW:0] DEPTH_CNT = (AW+1)'(DEPTH);
    localparam logic [AW:0] ONE_CNT   = (AW+1)'(1);

    // ------------------------------------------------------------------
    // Control registers
    // ------------------------------------------------------------------
    logic [7:0]    interrupt_enable_reg;
    logic [7:0]    fifo_control_reg;
    logic [7:0]    line_control_reg;
    logic [7:0]    modem_control_reg;
    logic [7:0]    scratch_pad;
    // Power-up values only; the reset pin leaves the divisor alone.
    logic [7:0]    baud_divisor_low  = ULMS_PWR_DIV_LOW;  // [R18]
    logic [7:0]    baud_divisor_high = ULMS_PWR_DIV_HIGH; // [R18]
    logic          overrun;
    logic [3:0]    modem_delta;
    logic [3:0]    modem_prev_n;
    logic          break_armed;
    logic [10:0]   rx_mem [DEPTH];
    logic [7:0]    tx_mem [DEPTH];
    logic [AW-1:0] rx_wr_ptr;
    logic [AW-1:0] rx_rd_ptr;
    logic [AW:0]   rx_count;
    logic [AW:0]   rx_err_count;
    logic [AW-1:0] tx_wr_ptr;
    logic [AW-1:0] tx_rd_ptr;
    logic [AW:0]   tx_count;
    logic          snap_pop;
    logic          snap_overrun;
    logic [3:0]    snap_delta;

    logic          acc_wr;
    logic          acc_rd;
    logic          setup;
    logic          hit;
    logic [7:0]    rd_value;
    logic          fifo_en;
    logic          rx_full;
    logic          tx_full;
    logic [7:0]    rx_mask;
    logic          data_par;
    logic          parity_bad;
    logic          rx_accept;
    logic          rx_push;
    logic          rx_pop;
    logic [10:0]   rx_entry;
    logic [10:0]   rx_head;
    logic          tx_push;
    logic          tx_pop;
    logic          rx_clear;
    logic          tx_clear;
    logic [3:0]    modem_now_n;
    logic [3:0]    modem_change;
    logic [7:0]    line_status;
    logic [7:0]    modem_status;
    logic [7:0]    interrupt_status_reg;
    logic [4:0]    trigger;

    assign setup   = psel & ~penable;
    assign acc_wr  = psel & penable & pwrite;
    assign acc_rd  = psel & penable & ~pwrite;
    assign pready  = 1'b1;
    assign pslverr = psel & penable & ~hit;
    assign fifo_en = fifo_control_reg[ULMS_FCR_EN_BIT];
    assign loopback = modem_control_reg[ULMS_MCR_LOOP_BIT];                        // [R21]
    assign interrupt_output_enable = modem_control_reg[ULMS_MCR_OUT2_BIT];
    assign baud_divisor = {baud_divisor_high, baud_divisor_low};                   // [R17]
    assign line_control = line_control_reg;

    // ------------------------------------------------------------------
    // Address decode and read data
    // ------------------------------------------------------------------
    always_comb begin
        hit      = 1'b1;
        rd_value = 8'h00;
        if (paddr == ULMS_ADDR_HOLDING) begin
            rd_value = rx_head[7:0];
        end else if (paddr == ULMS_ADDR_INT_EN) begin
            rd_value = interrupt_enable_reg;
        end else if (paddr == ULMS_ADDR_INT_FIFO) begin
            rd_value = interrupt_status_reg;
        end else if (paddr == ULMS_ADDR_LINE_CTL) begin
            rd_value = line_control_reg;
        end else if (paddr == ULMS_ADDR_MODEM_CTL) begin
            rd_value = modem_control_reg;
        end else if (paddr == ULMS_ADDR_LINE_STS) begin
            rd_value = line_status;
        end else if (paddr == ULMS_ADDR_MODEM_STS) begin
            rd_value = modem_status;
        end else if (paddr == ULMS_ADDR_SCRATCH) begin
            rd_value = scratch_pad;                                                 // [R16]
        end else if (paddr == ULMS_ADDR_DIV_LOW) begin
            rd_value = baud_divisor_low;
        end else if (paddr == ULMS_ADDR_DIV_HIGH) begin
            rd_value = baud_divisor_high;
        end else begin
            hit = 1'b0;
        end
    end

    // Read data is captured in the setup cycle, together with what that
    // read will clear or pop, so a later event is never thrown away.
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            prdata       <= 32'h0000_0000;
            snap_pop     <= 1'b0;
            snap_overrun <= 1'b0;
            snap_delta   <= 4'h0;
        end else if (setup && !pwrite) begin
            prdata       <= {24'h00_0000, rd_value};
            snap_pop     <= (paddr == ULMS_ADDR_HOLDING) && (rx_count != '0);
            snap_overrun <= (paddr == ULMS_ADDR_LINE_STS) && overrun;
            snap_delta   <= (paddr == ULMS_ADDR_MODEM_STS) ? modem_delta : 4'h0;
        end
    end

    // ------------------------------------------------------------------
    // Control register writes
    // ------------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            interrupt_enable_reg <= ULMS_RST_INT_EN;                               // [R23]
            fifo_control_reg     <= ULMS_RST_FIFO_CTL;                             // [R23]
            line_control_reg     <= ULMS_RST_LINE_CTL;                             // [R23]
            modem_control_reg    <= ULMS_RST_MODEM_CTL;                            // [R23]
            scratch_pad          <= ULMS_RST_SCRATCH;                              // [R23]
        end else if (acc_wr) begin
            if (paddr == ULMS_ADDR_INT_EN) begin
                interrupt_enable_reg <= pwdata[7:0];
            end else if (paddr == ULMS_ADDR_INT_FIFO) begin
                // Clear bits self-clear, so only enable, DMA and trigger are kept.
                fifo_control_reg <= pwdata[7:0] & 8'hc9;
            end else if (paddr == ULMS_ADDR_LINE_CTL) begin
                line_control_reg <= pwdata[7:0];
            end else if (paddr == ULMS_ADDR_MODEM_CTL) begin
                modem_control_reg <= pwdata[7:0] & 8'h1f;
            end else if (paddr == ULMS_ADDR_SCRATCH) begin
                scratch_pad <= pwdata[7:0];                                        // [R16]
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (acc_wr && paddr == ULMS_ADDR_DIV_LOW) begin
            baud_divisor_low <= pwdata[7:0];
        end
        if (acc_wr && paddr == ULMS_ADDR_DIV_HIGH) begin
            baud_divisor_high <= pwdata[7:0];
        end
    end

    // ------------------------------------------------------------------
    // Receive path
    // ------------------------------------------------------------------
    assign rx_full  = fifo_en ? (rx_count == DEPTH_CNT) : (rx_count == ONE_CNT);
    assign rx_clear = acc_wr && paddr == ULMS_ADDR_INT_FIFO
                      && (pwdata[ULMS_FCR_RXCLR_BIT] || pwdata[ULMS_FCR_EN_BIT] != fifo_en);
    assign tx_clear = acc_wr && paddr == ULMS_ADDR_INT_FIFO
                      && (pwdata[ULMS_FCR_TXCLR_BIT] || pwdata[ULMS_FCR_EN_BIT] != fifo_en);

    always_comb begin
        case (line_control_reg[1:0])
            2'd0:    rx_mask = 8'h1f;
            2'd1:    rx_mask = 8'h3f;
            2'd2:    rx_mask = 8'h7f;
            default: rx_mask = 8'hff;
        endcase
    end

    assign data_par = ^(rx_char_data & rx_mask);
    assign parity_bad = line_control_reg[ULMS_LCR_PAR_EN] &                         // [R3]
        (line_control_reg[ULMS_LCR_PAR_FORCE]
            ? (rx_parity_bit == line_control_reg[ULMS_LCR_PAR_EVEN])
            : (line_control_reg[ULMS_LCR_PAR_EVEN] ? (data_par ^ rx_parity_bit)
                                                   : ~(data_par ^ rx_parity_bit)));

    // A break replaces the character of its frame and is taken only when armed.
    assign rx_accept = (rx_break && break_armed) || (rx_char_valid && !rx_break);  // [R6]
    assign rx_entry  = rx_break ? {1'b1, 1'b0, 1'b0, 8'h00}                         // [R5]
                                : {1'b0, ~rx_stop_bit, parity_bad, rx_char_data};  // [R4]
    assign rx_push   = rx_accept && !rx_full && !rx_clear;                          // [R2]
    assign rx_pop    = acc_rd && paddr == ULMS_ADDR_HOLDING && snap_pop && !rx_clear;
    assign rx_head   = rx_mem[rx_rd_ptr];
    assign rx_line   = loopback ? tx_serial : rx_pin;

    always_ff @(posedge core_clk) begin
        if (rx_push) begin
            rx_mem[rx_wr_ptr] <= rx_entry;
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst || rx_clear) begin
            rx_wr_ptr    <= '0;
            rx_rd_ptr    <= '0;
            rx_count     <= '0;
            rx_err_count <= '0;
        end else begin
            if (rx_push) begin
                rx_wr_ptr <= (rx_wr_ptr == AW'(DEPTH - 1)) ? '0 : rx_wr_ptr + 1'b1;
            end
            if (rx_pop) begin
                rx_rd_ptr <= (rx_rd_ptr == AW'(DEPTH - 1)) ? '0 : rx_rd_ptr + 1'b1;
            end
            rx_count <= rx_count + (rx_push ? ONE_CNT : '0) - (rx_pop ? ONE_CNT : '0);
            rx_err_count <= rx_err_count                                            // [R10]
                + ((rx_push && |rx_entry[10:8]) ? ONE_CNT : '0)
                - ((rx_pop && |rx_head[10:8]) ? ONE_CNT : '0);
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            overrun     <= 1'b0;
            break_armed <= 1'b1;
        end else begin
            if (rx_accept && rx_full) begin
                overrun <= 1'b1;                                                    // [R2]
            end else if (acc_rd && paddr == ULMS_ADDR_LINE_STS && snap_overrun) begin
                overrun <= 1'b0;
            end
            if (rx_break && break_armed) begin
                break_armed <= 1'b0;                                                // [R6]
            end else if (rx_line) begin
                break_armed <= 1'b1;                                                // [R6]
            end
        end
    end

    // ------------------------------------------------------------------
    // Transmit path
    // ------------------------------------------------------------------
    assign tx_full = fifo_en ? (tx_count == DEPTH_CNT) : (tx_count == ONE_CNT);
    assign tx_push = acc_wr && paddr == ULMS_ADDR_HOLDING && !tx_full && !tx_clear;
    assign tx_pop  = tx_take && tx_data_valid && !tx_clear;
    assign tx_data = tx_mem[tx_rd_ptr];
    // Loopback feeds clear-to-send from the request-to-send control bit.
    assign tx_halt = loopback ? ~modem_control_reg[ULMS_MCR_RTS_BIT] : cts_n;       // [R13]
    assign tx_data_valid = (tx_count != '0) && !tx_halt;                            // [R13]

    always_ff @(posedge core_clk) begin
        if (tx_push) begin
            tx_mem[tx_wr_ptr] <= pwdata[7:0];
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst || tx_clear) begin
            tx_wr_ptr <= '0;
            tx_rd_ptr <= '0;
            tx_count  <= '0;
        end else begin
            if (tx_push) begin
                tx_wr_ptr <= (tx_wr_ptr == AW'(DEPTH - 1)) ? '0 : tx_wr_ptr + 1'b1;
            end
            if (tx_pop) begin
                tx_rd_ptr <= (tx_rd_ptr == AW'(DEPTH - 1)) ? '0 : tx_rd_ptr + 1'b1;
            end
            tx_count <= tx_count + (tx_push ? ONE_CNT : '0) - (tx_pop ? ONE_CNT : '0);
        end
    end

    // ------------------------------------------------------------------
    // Modem inputs and outputs
    // ------------------------------------------------------------------
    // Order is carrier, ring, data-set-ready, clear-to-send, all active low.
    assign modem_now_n = loopback                                                   // [R15]
        ? ~{modem_control_reg[ULMS_MCR_OUT2_BIT], modem_control_reg[ULMS_MCR_OUT1_BIT],
            modem_control_reg[ULMS_MCR_DTR_BIT], modem_control_reg[ULMS_MCR_RTS_BIT]}
        : {carrier_detect_n, ring_indicator_n, dsr_n, cts_n};
    assign modem_change = {modem_now_n[3] ^ modem_prev_n[3],                        // [R11]
                           ~modem_prev_n[2] & modem_now_n[2],                       // [R12]
                           modem_now_n[1] ^ modem_prev_n[1],
                           modem_now_n[0] ^ modem_prev_n[0]};

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            modem_delta  <= 4'h0;                                                   // [R19]
            modem_prev_n <= modem_now_n;                                            // [R19]
        end else begin
            modem_prev_n <= modem_now_n;
            // A change in the clearing cycle survives the clear.
            modem_delta <= modem_change                                             // [R11]
                | (modem_delta & ~((acc_rd && paddr == ULMS_ADDR_MODEM_STS)         // [R22]
                                   ? snap_delta : 4'h0));
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            rts_n  <= 1'b1;                                                         // [R23]
            dtr_n  <= 1'b1;                                                         // [R23]
            tx_pin <= 1'b1;                                                         // [R23]
        end else begin
            rts_n  <= loopback | ~modem_control_reg[ULMS_MCR_RTS_BIT];              // [R21]
            dtr_n  <= loopback | ~modem_control_reg[ULMS_MCR_DTR_BIT];
            tx_pin <= loopback | (tx_serial & ~line_control_reg[ULMS_LCR_TX_BREAK]);
        end
    end

    // ------------------------------------------------------------------
    // Status composition
    // ------------------------------------------------------------------
    assign line_status = {rx_err_count != '0,                                       // [R10]
                          (tx_count == '0) && !tx_shift_busy,                       // [R9]
                          tx_count == '0,                                           // [R7] [R8]
                          (rx_count != '0) ? rx_head[10:8] : 3'b000,                // [R3] [R4] [R5]
                          overrun,
                          rx_count != '0};                                          // [R1]
    assign modem_status = {~modem_now_n, modem_delta};                              // [R14] [R15]

    assign line_irq_req = interrupt_enable_reg[ULMS_IER_LINE_BIT]                   // [R20]
                          && (overrun || line_status[4:2] != 3'b000);
    assign modem_irq_req = interrupt_enable_reg[ULMS_IER_MODEM_BIT] && |modem_delta; // [R11]
    assign interrupt_status_reg = {{2{fifo_en}}, 2'b00,
                                   line_irq_req ? ULMS_ID_LINE : ULMS_ID_MODEM,
                                   ~(line_irq_req | modem_irq_req)};                // [R23]

    always_comb begin
        case (fifo_control_reg[ULMS_FCR_TRIG_LSB +: 2])
            2'd0:    trigger = ULMS_TRIG_0;
            2'd1:    trigger = ULMS_TRIG_1;
            2'd2:    trigger = ULMS_TRIG_2;
            default: trigger = ULMS_TRIG_3;
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            receive_ready_n  <= 1'b1;                                               // [R24]
            transmit_ready_n <= 1'b0;                                               // [R24]
        end else if (fifo_control_reg[ULMS_FCR_DMA_BIT] && fifo_en) begin
            receive_ready_n  <= 5'(rx_count) < trigger;
            transmit_ready_n <= tx_full;
        end else begin
            receive_ready_n  <= rx_count == '0;
            transmit_ready_n <= tx_count != '0;
        end
    end

endmodule // ulms_top

// [bench/ulms_checker.sv]
`timescale 1ns/10ps
module ulms_checker (
    input wire logic core_clk, sys_rst, psel, rx_pin, rx_line, tx_serial, tx_pin,
    input wire logic tx_halt, tx_data_valid, cts_n, loopback, rts_n, dtr_n,
    input wire logic receive_ready_n, transmit_ready_n, line_irq_req, modem_irq_req,
    input wire logic [15:0] baud_divisor
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (sys_rst);
    a_loop_line: assert property (loopback |-> rx_line == tx_serial)
        else $error("loop rx line");
    a_norm_line: assert property (!loopback |-> rx_line == rx_pin)
        else $error("rx line not pin");
    a_loop_pins: assert property ($past(loopback) |-> rts_n && dtr_n && tx_pin)
        else $error("loop pins");
    a_halt_cts: assert property (!loopback |-> tx_halt == cts_n)
        else $error("halt not cts");
    a_halt_valid: assert property (tx_halt |-> !tx_data_valid)
        else $error("valid while halted");
    a_rst_pins: assert property ($past(sys_rst) |-> rts_n && dtr_n && tx_pin &&
        receive_ready_n && !transmit_ready_n) else $error("reset pins");
    a_modem_hold: assert property (modem_irq_req && !psel |=> modem_irq_req)
        else $error("modem req lost");
    a_line_hold: assert property (line_irq_req && !psel |=> line_irq_req)
        else $error("line req lost");
    a_div_keep: assert property ($fell(sys_rst) |-> $stable(baud_divisor))
        else $error("divisor reset");
    cover property (line_irq_req);
    cover property (modem_irq_req);
    cover property (loopback && tx_halt);
endmodule // ulms_checker
bind ulms_top ulms_checker u_chk (.*);

// [bench/ulms_partner.sv]
`timescale 1ns/10ps
module ulms_partner #(
    parameter int BUSY = 12
) (
    input  wire logic core_clk,
    input  wire logic tx_data_valid,
    output logic      tx_take,
    output logic      tx_shift_busy,
    output logic      tx_serial
);
    int cnt = 0;
    initial tx_take = 1'b0;
    // The shifter takes one byte, then stays busy for a whole character time.
    always @(posedge core_clk) begin
        tx_take <= tx_data_valid && !tx_shift_busy;
        if (tx_take)
            cnt <= BUSY;
        else if (cnt > 0)
            cnt <= cnt - 1;
    end
    assign tx_shift_busy = tx_take || cnt > 0;
    assign tx_serial = tx_shift_busy ? cnt[0] : 1'b1;
endmodule // ulms_partner

// [bench/test_uart_line_modem_status.sv]
`timescale 1ns/10ps
module test_uart_line_modem_status;
    import ulms_pkg::*;
    logic core_clk = 0, sys_rst = 1, psel = 0, penable = 0, pwrite = 0, rx_char_valid = 0;
    logic rx_parity_bit = 0, rx_stop_bit = 1, rx_break = 0, rx_pin = 1;
    logic cts_n = 1, dsr_n = 1, ring_indicator_n = 1, carrier_detect_n = 1;
    logic [7:0] paddr = '0, rx_char_data = '0, tx_data, line_control;
    logic [31:0] pwdata = '0, prdata, rdat;
    logic [15:0] baud_divisor;
    logic pready, pslverr, rx_line, tx_data_valid, tx_take, tx_shift_busy, tx_serial, tx_pin;
    logic tx_halt, rts_n, dtr_n, loopback, interrupt_output_enable, receive_ready_n;
    logic transmit_ready_n, line_irq_req, modem_irq_req, serr;
    int errors = 0, num_checks = 0, cyc = 0;
    integer seed = 32'hf14a2260;
    ulms_top #(.DEPTH(4)) uut (.*);
    ulms_partner #(.BUSY(12)) far (.*);
    initial forever #10 core_clk = ~core_clk;
    task finish_test;
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            errors++;
            finish_test();
        end
    end
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            errors++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
        @(posedge core_clk);
        penable <= 1'b1;
        do @(posedge core_clk); while (pready !== 1'b1);
        rdat = prdata;
        serr = pslverr;
        {psel, penable} <= 2'b00;
    endtask
    task rd(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, '0);
        chk(rdat, exp);
    endtask
    task rxc(input logic [7:0] d, input logic p, input logic s, input logic b);
        @(posedge core_clk);
        {rx_char_data, rx_parity_bit, rx_stop_bit, rx_char_valid, rx_break} <= {d, p, s, !b, b};
        @(posedge core_clk);
        {rx_char_data, rx_char_valid, rx_break} <= {~d, 2'b00};
    endtask
    function automatic logic [31:0] mup();
        return {24'h0, ~carrier_detect_n, ~ring_indicator_n, ~dsr_n, ~cts_n, 4'h0};
    endfunction
    initial begin
        logic [7:0] v;
        logic [15:0] dv;
        {cts_n, dsr_n, ring_indicator_n, carrier_detect_n} <= 4'($random(seed));
        repeat (20) @(posedge core_clk);
        sys_rst <= 1'b0;
        rd(ULMS_ADDR_LINE_STS, 32'h60);
        rd(ULMS_ADDR_SCRATCH, 32'hff);
        rd(ULMS_ADDR_INT_FIFO, 32'h01);
        rd(ULMS_ADDR_DIV_LOW, 32'h01);
        rd(ULMS_ADDR_DIV_HIGH, 32'h00);
        rd(ULMS_ADDR_MODEM_STS, mup());
        v = 8'($random(seed));
        apb(1'b1, ULMS_ADDR_SCRATCH, 32'(v));
        apb(1'b1, 8'h3c, 32'h5a);
        chk(32'(serr), 32'h1);
        rd(ULMS_ADDR_SCRATCH, 32'(v));
        dv = 16'($random(seed));
        apb(1'b1, ULMS_ADDR_DIV_LOW, 32'(dv[7:0]));
        apb(1'b1, ULMS_ADDR_DIV_HIGH, 32'(dv[15:8]));
        sys_rst <= 1'b1;
        @(posedge core_clk);
        chk(32'(baud_divisor), 32'(dv));
        sys_rst <= 1'b0;
        @(posedge core_clk);
        chk(32'(baud_divisor), 32'(dv));
        apb(1'b1, ULMS_ADDR_INT_FIFO, 32'h01);
        apb(1'b1, ULMS_ADDR_INT_EN, 32'h0c);
        apb(1'b1, ULMS_ADDR_LINE_CTL, 32'h0b);
        rxc(v, ^v, 1'b0, 1'b0);
        rxc(~v, ~^v, 1'b1, 1'b0);
        rd(ULMS_ADDR_LINE_STS, 32'hed);
        rd(ULMS_ADDR_HOLDING, 32'(v));
        rd(ULMS_ADDR_LINE_STS, 32'h61);
        rd(ULMS_ADDR_HOLDING, {24'h0, ~v});
        for (int i = 0; i < 5; i++) rxc(8'(i), ~^8'(i), 1'b1, 1'b0);
        rd(ULMS_ADDR_LINE_STS, 32'h63);
        for (int i = 0; i < 4; i++) rd(ULMS_ADDR_HOLDING, i);
        rd(ULMS_ADDR_LINE_STS, 32'h60);
        rx_pin <= 1'b0;
        rxc('0, 1'b0, 1'b0, 1'b1);
        rxc('0, 1'b0, 1'b0, 1'b1);
        rd(ULMS_ADDR_LINE_STS, 32'hf1);
        rd(ULMS_ADDR_HOLDING, 32'h0);
        rd(ULMS_ADDR_LINE_STS, 32'h60);
        rx_pin <= 1'b1;
        cts_n <= 1'b1;
        apb(1'b1, ULMS_ADDR_HOLDING, 32'(v));
        rd(ULMS_ADDR_LINE_STS, 32'h00);
        cts_n <= 1'b0;
        repeat (40) @(posedge core_clk);
        rd(ULMS_ADDR_LINE_STS, 32'h60);
        chk(32'(modem_irq_req), 32'h1);
        rd(ULMS_ADDR_MODEM_STS, mup() | 32'h1);
        {dsr_n, carrier_detect_n, ring_indicator_n} <= {~dsr_n, ~carrier_detect_n, 1'b0};
        repeat (3) @(posedge core_clk);
        rd(ULMS_ADDR_MODEM_STS, mup() | 32'ha);
        ring_indicator_n <= 1'b1;
        repeat (3) @(posedge core_clk);
        rd(ULMS_ADDR_MODEM_STS, mup() | 32'h4);
        rd(ULMS_ADDR_MODEM_STS, mup());
        for (int i = 0; i < 4; i++) begin
            apb(1'b1, ULMS_ADDR_MODEM_CTL, 32'h10 | (32'h1 << i));
            apb(1'b0, ULMS_ADDR_MODEM_STS, '0);
            chk(32'(rdat[7:4]), 32'h1 << (i ^ (i < 2)));
        end
        apb(1'b1, ULMS_ADDR_MODEM_CTL, 32'h0);
        finish_test();
    end
endmodule // test_uart_line_modem_status
